// ### bench/relay_watch.sv
/*
 * relay load model: counts energize events on one relay output.
 * assumes relay_o is registered on ref_clk_i.
 */
`timescale 1ns/1ps
module relay_watch #(
	parameter WATCH = 1
) (
	// clock and reset
	input wire ref_clk_i,
	input wire resetn_i,
	// relay levels from the device
	input wire [3:0] relay_o,
	// energize count
	output reg [7:0] rise_cnt_o
);
	// last level seen, to find rising edges
	reg last_q;
	// a coil only cares about off to on changes
	always @(posedge ref_clk_i)
	begin
		last_q <= relay_o[WATCH] & resetn_i;
		if (!resetn_i)
			rise_cnt_o <= 8'h00;
		else if (relay_o[WATCH] && !last_q)
			rise_cnt_o <= rise_cnt_o + 8'h01;
	end
endmodule // relay_watch

// ### bench/setpoint_alarm_controller_bench.sv
/*
 * bench: apb master, line tick source and trigger drivers.
 * assumes the register map of setpoint_defines.vh, both line periods.
 */
`timescale 1ns/1ps
`include "setpoint_defines.vh"
module setpoint_alarm_controller_bench;
	// ****************************************************************
	// signals
	// ****************************************************************
	reg ref_clk_i = 0;
	reg resetn_i = 0;
	reg clk_en_i = 1;
	reg cycle_tick_i = 0;
	reg [255:0] analog_i = 0;
	reg [15:0] binary_i = 0;
	reg psel_i = 0;
	reg penable_i = 0;
	reg pwrite_i = 0;
	reg [11:0] paddr_i = 0;
	reg [31:0] pwdata_i = 0;
	wire [31:0] prdata_o;
	wire pready_o;
	wire pslverr_o;
	wire irq_o;
	wire [3:0] relay_o;
	wire [7:0] rises;
	reg [31:0] rd;
	reg err;
	integer fail_count = 0;
	integer n_tests = 0;
	integer cyc = 0;
	// clock enable dropped once to check that a tick is ignored
	setpoint_alarm_controller dut (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.cycle_tick_i(cycle_tick_i),
		.analog_i(analog_i),
		.binary_i(binary_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.relay_o(relay_o),
		.irq_o(irq_o)
	);
	relay_watch u_watch (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.relay_o(relay_o),
		.rise_cnt_o(rises)
	);
	initial forever #4 ref_clk_i = ~ref_clk_i;
	// run needs about 800 cycles; ceiling leaves ample slack
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			fail_count = fail_count + 1;
			report_and_stop;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask
	// one apb transfer, held until pready is sampled high
	task xfer(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge ref_clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1;
		@(posedge ref_clk_i);
		while (pready_o !== 1'b1)
			@(posedge ref_clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	end
	endtask
	// line cycles, spaced wider than one scan
	task tick(input integer n);
		repeat (n)
		begin
			@(posedge ref_clk_i);
			cycle_tick_i <= 1;
			@(posedge ref_clk_i);
			cycle_tick_i <= 0;
			repeat (18) @(posedge ref_clk_i);
		end
	endtask
	task cfg(input [3:0] sp, input [31:0] tg, op, rl, od, rdl, act);
		reg [11:0] b;
	begin
		b = `A_CFG_BASE + sp * 12'h020;
		xfer(1, b, tg);
		xfer(1, b + 12'h004, op);
		xfer(1, b + 12'h008, rl);
		xfer(1, b + 12'h00C, od);
		xfer(1, b + 12'h010, rdl);
		xfer(1, b + 12'h014, act);
	end
	endtask
	task t_reset;
	begin
		xfer(0, `A_STATUS, 0);
		chk(rd, 0);
		xfer(0, `A_LATCH, 0);
		chk(rd, 0);
		xfer(0, `A_CFG_BASE + 12'h1EC, 0);
		chk(rd, 1);
		xfer(0, `A_CFG_BASE + 12'h018, 0);
		chk(err, 1);
		$display("reset test done");
	end
	endtask
	// hysteresis, operate delay restart, latch
	task t_analog;
	begin
		// idle setpoints watch channel 0 with zero limits; keep it
		// negative so they never operate, and test on channel 1
		analog_i[31:0] <= 32'hFFFF_FFFF;
		cfg(0, 1, 100, 50, 1, 0, 1);
		xfer(1, `A_CTRL, 1);
		analog_i[63:32] <= 100;
		tick(4);
		analog_i[63:32] <= 99;
		tick(1);
		analog_i[63:32] <= 100;
		tick(4);
		xfer(0, `A_STATUS, 0);
		chk(rd, 0);
		tick(1);
		xfer(0, `A_STATUS, 0);
		chk(rd, 1);
		chk(relay_o, 1);
		analog_i[63:32] <= 51;
		tick(1);
		xfer(0, `A_STATUS, 0);
		chk(rd, 1);
		analog_i[63:32] <= 50;
		tick(1);
		xfer(0, `A_STATUS, 0);
		chk(rd, 0);
		chk(relay_o, 0);
		xfer(0, `A_LATCH, 0);
		chk(rd, 1);
		xfer(1, `A_LATCH_CLR, 1);
		xfer(0, `A_LATCH, 0);
		chk(rd, 0);
		$display("analog test done");
	end
	endtask
	// level triggers, counter wrap, relay or, interrupt
	task t_binary;
	begin
		cfg(1, 32'h102, 0, 0, 0, 0, 32'h12);
		cfg(2, 32'h103, 0, 0, 0, 0, 32'h11);
		cfg(3, 32'h104, 0, 0, 0, 0, 32'h11);
		xfer(1, `A_CNT_BASE + 12'h004, 32'h000F_423F);
		xfer(1, `A_IRQ_CLR, 32'h0000_FFFF);
		xfer(1, `A_IRQ_EN, 0);
		binary_i[4:2] <= 3'b111;
		tick(2);
		xfer(0, `A_STATUS, 0);
		chk(rd, 32'h0000_000E);
		xfer(0, `A_CNT_BASE + 12'h004, 0);
		chk(rd, 0);
		chk(relay_o, 2);
		chk(irq_o, 0);
		xfer(1, `A_IRQ_EN, 2);
		repeat (2) @(posedge ref_clk_i);
		chk(irq_o, 1);
		xfer(1, `A_IRQ_CLR, 2);
		repeat (2) @(posedge ref_clk_i);
		chk(irq_o, 0);
		binary_i[3:2] <= 2'b00;
		tick(1);
		chk(relay_o, 2);
		binary_i[4] <= 0;
		tick(1);
		chk(relay_o, 0);
		chk(rises, 1);
		// a frozen engine must ignore a tick that would operate
		clk_en_i <= 0;
		binary_i[4] <= 1;
		tick(1);
		clk_en_i <= 1;
		binary_i[4] <= 0;
		xfer(0, `A_STATUS, 0);
		chk(rd, 0);
		$display("binary test done");
	end
	endtask
	// equal limits, latched relay, 60 hz timing, time counter
	task t_latched;
	begin
		cfg(4, 2, 10, 10, 0, 0, 32'h21);
		cfg(5, 32'h105, 0, 0, 1, 0, 32'h33);
		xfer(1, `A_CTRL, 3);
		xfer(1, `A_RLY_LMODE, 4);
		analog_i[95:64] <= 11;
		binary_i[5] <= 1;
		// 166 units a scan: six scans stay short of 0.1 s
		tick(6);
		xfer(0, `A_STATUS, 0);
		chk(rd, 32'h0000_0010);
		chk(relay_o, 4);
		analog_i[95:64] <= 9;
		tick(1);
		xfer(0, `A_STATUS, 0);
		chk(rd, 32'h0000_0020);
		chk(relay_o, 4);
		xfer(1, `A_RLY_REL, 4);
		tick(1);
		chk(relay_o, 0);
		// time action neither steps on entry nor per scan
		xfer(0, `A_CNT_BASE + 12'h00C, 0);
		chk(rd, 0);
		$display("latched relay test done");
	end
	endtask
	task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk_i);
		resetn_i <= 1;
		t_reset;
		t_analog;
		t_binary;
		t_latched;
		report_and_stop;
	end
endmodule // setpoint_alarm_controller_bench

// ### bench/setpoint_assertions.sv
/*
 * port checker for the setpoint controller.
 * assumes clk_en_i is high whenever a scan runs and ticks come at
 * least 17 cycles apart.
 */
`timescale 1ns/1ps
module setpoint_checker (
	// clock and reset
	input wire ref_clk_i,
	input wire resetn_i,
	// watched ports
	input wire cycle_tick_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire [3:0] relay_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	// ****************************************************************
	// apb steps
	// ****************************************************************
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_answer;
		psel_i && penable_i && !pready_o ##1 pready_o;
	endsequence
	a_apb_wait_state: assert property (s_setup |=> s_answer)
		else $error("apb answer not after one wait state");
	a_ready_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("pready held too long");
	a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("pready outside access");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	a_err_data_zero: assert property
		(pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
		else $error("refused read data not zero");
	a_rdata_on_ready: assert property (!$stable(prdata_o) |-> pready_o)
		else $error("read data moved without answer");
	// relays move only at the end of a scan
	a_relay_scan_end: assert property
		(!$stable(relay_o) |-> $past(cycle_tick_i, 16)
		|| $past(cycle_tick_i, 17))
		else $error("relay changed outside scan end");
	a_relay_per_scan: assert property
		(!$stable(relay_o) |=> $stable(relay_o) [*8])
		else $error("relay changed twice in one scan");
endmodule // setpoint_checker

bind setpoint_alarm_controller setpoint_checker u_chk (
	.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i),
	.cycle_tick_i(cycle_tick_i),
	.psel_i(psel_i),
	.penable_i(penable_i),
	.pwrite_i(pwrite_i),
	.prdata_o(prdata_o),
	.pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.relay_o(relay_o)
);

// ### hdl/setpoint_alarm_controller.v
/*
 * setpoint engine: sixteen setpoints scanned once per line cycle,
 * hysteresis or level triggers, operate/release delays, status and
 * latch registers, relay or counter actions, apb register access.
 * assumes cycle_tick_i pulses once per measured line cycle and that
 * trigger inputs are synchronous to ref_clk_i.
 */
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "setpoint_defines.vh"

// Behaviour
// - sixteen setpoints, one trigger argument each
// - all setpoints scanned once per line cycle
// - true expression fires relay or counter action
// - analog operates on reaching operate threshold
// - analog releases on reaching release threshold
// - binary triggers are level sensitive, no thresholds
// - programmable operate delay before operating
// - programmable release delay before releasing
// - status changes only after delay fully held
// - every status change updates status register
// - operate latched until explicitly cleared
// - count action fires on transition into operated
// - counters independent, relays ORed across setpoints
// - relay held until all release, or command
// - time counter accumulates operated time, 0.1 h
// - four general counters of six decimal digits
module setpoint_alarm_controller #(
	parameter N_ANA = 8,
	parameter N_BIN = 16
) (
	// clock, reset, enable
	input wire ref_clk_i,
	input wire resetn_i,
	input wire clk_en_i,
	// line cycle strobe and trigger sources
	input wire cycle_tick_i,
	input wire [N_ANA*32-1:0] analog_i,
	input wire [N_BIN-1:0] binary_i,
	// apb slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// outputs to the system
	output reg [3:0] relay_o,
	output reg irq_o
);

	// ****************************************************************
	// functions
	// ****************************************************************

	// threshold reached in the direction of the alarm
	function reaches;
		input signed [31:0] v;
		input signed [31:0] thr;
		input high;
		begin
			reaches = high ? (v >= thr) : (v <= thr);
		end
	endfunction

	// six decimal digit counter step, wraps to zero
	function [19:0] cnt_inc;
		input [19:0] c;
		begin
			cnt_inc = (c == `CNT_MAX) ? 20'h0_0000 : c + 20'h0_0001;
		end
	endfunction

	// ****************************************************************
	// storage
	// ****************************************************************
	reg [8:0] trigger_select_q [0:15]; // bit 8 binary, low bits source
	reg [31:0] op_thr_q [0:15]; // operate limit, primary units
	reg [31:0] rel_thr_q [0:15]; // release limit
	reg [13:0] op_dly_q [0:15]; // 0.1 s units
	reg [13:0] rel_dly_q [0:15]; // 0.1 s units
	reg [5:0] act_q [0:15]; // [1:0] code, [5:4] target
	reg [23:0] tmr_q [0:15]; // elapsed qualify time, 0.1 ms
	reg [19:0] cnt_q [0:3]; // general counters
	reg [21:0] frac_q [0:3]; // sub 0.1 hour residue
	reg [1:0] ctrl_q; // enable, 60 hz
	reg [15:0] stat_q; // setpoint status
	reg [15:0] latch_q; // alarm latch
	reg [15:0] irq_stat_q; // status change events
	reg [15:0] irq_en_q;
	reg [3:0] lmode_q; // latched relay mask
	reg [3:0] rel_pend_q; // pending release commands
	reg [3:0] rly_acc_q; // relay requests gathered in a scan
	reg busy_q;
	reg [3:0] idx_q;
	integer i; // loop index of the scan engine reset
	integer j; // loop index of the configuration reset

	// ****************************************************************
	// evaluation of the setpoint under scan
	// ****************************************************************
	wire [8:0] tg = trigger_select_q[idx_q];
	wire [31:0] othr = op_thr_q[idx_q];
	wire [31:0] rthr = rel_thr_q[idx_q];
	wire [5:0] act = act_q[idx_q];
	wire [1:0] tgt = act[5:4];
	wire st = stat_q[idx_q];
	wire signed [31:0] av = analog_i[tg[2:0]*32 +: 32];
	wire bin = binary_i[tg[3:0]];
	// operate above release means a high alarm, else a low alarm;
	// equal limits behave as a high alarm with no dead band
	wire hi = $signed(othr) >= $signed(rthr);
	wire op_c = tg[`TRIGGER_SELECT_BIN_BIT] ? bin : reaches(av, othr, hi);
	wire rel_c = tg[`TRIGGER_SELECT_BIN_BIT] ? ~bin : reaches(av, rthr, ~hi);
	wire qual = st ? rel_c : op_c;
	wire [9:0] per = ctrl_q[`CTRL_60HZ_BIT] ? `PER_60HZ : `PER_50HZ;
	wire [23:0] t_next = tmr_q[idx_q] + {14'h0, per};
	wire [13:0] dly = st ? rel_dly_q[idx_q] : op_dly_q[idx_q];
	wire [23:0] lim = {10'h0, dly} * `DLY_SCALE;
	wire flip = busy_q & qual & (t_next >= lim);
	wire new_st = st ^ flip;
	wire rise = flip & ~st;
	wire [15:0] one_hot = 16'h0001 << idx_q;
	wire [3:0] rly_one = 4'h1 << tgt;
	wire [3:0] rly_now = (busy_q & new_st & (act[1:0] == `ACT_RELAY))
		? rly_one : 4'h0;
	wire [21:0] frac_next = frac_q[tgt] + {12'h0, per};
	wire last = busy_q & (idx_q == 4'hF);

	// ****************************************************************
	// apb decode
	// ****************************************************************
	wire [11:0] off = paddr_i - `A_CFG_BASE;
	wire [3:0] csp = off[8:5];
	wire [2:0] cfld = off[4:2];
	wire in_cfg = (paddr_i >= `A_CFG_BASE) && (paddr_i < `A_CFG_END)
		&& (cfld <= `F_ACT);
	wire in_cnt = ((paddr_i >> 4) == (`A_CNT_BASE >> 4));
	wire wr = psel_i & penable_i & pready_o & pwrite_i;
	wire [15:0] latch_clr = (wr && paddr_i == `A_LATCH_CLR)
		? pwdata_i[15:0] : 16'h0000;
	wire [15:0] irq_clr = (wr && paddr_i == `A_IRQ_CLR)
		? pwdata_i[15:0] : 16'h0000;
	wire [3:0] rel_cmd = (wr && paddr_i == `A_RLY_REL)
		? pwdata_i[3:0] : 4'h0;
	reg [31:0] rd_d;
	reg hit_d;

	// read mux and address check
	always @*
	begin
		rd_d = 32'h0000_0000;
		hit_d = 1'b1;
		if (in_cfg)
		begin
			case (cfld)
				`F_TRIGGER_SELECT: rd_d = {23'h0, trigger_select_q[csp]};
				`F_OP_THR: rd_d = op_thr_q[csp];
				`F_REL_THR: rd_d = rel_thr_q[csp];
				`F_OP_DLY: rd_d = {18'h0, op_dly_q[csp]};
				`F_REL_DLY: rd_d = {18'h0, rel_dly_q[csp]};
				default: rd_d = {26'h0, act_q[csp]};
			endcase
		end
		else if (in_cnt)
			rd_d = {12'h0, cnt_q[paddr_i[3:2]]};
		else
		begin
			case (paddr_i)
				`A_CTRL: rd_d = {30'h0, ctrl_q};
				`A_STATUS: rd_d = {16'h0, stat_q};
				`A_LATCH: rd_d = {16'h0, latch_q};
				`A_RLY_LMODE: rd_d = {28'h0, lmode_q};
				`A_RLY_STATE: rd_d = {28'h0, relay_o};
				`A_IRQ_STAT: rd_d = {16'h0, irq_stat_q};
				`A_IRQ_EN: rd_d = {16'h0, irq_en_q};
				`A_LATCH_CLR, `A_RLY_REL, `A_IRQ_CLR: rd_d = 32'h0000_0000;
				default: hit_d = 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// apb handshake: one wait state, write commits as pready is seen
	// ****************************************************************
	always @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end
		else if (clk_en_i)
		begin
			if (psel_i && penable_i && !pready_o)
			begin
				pready_o <= 1'b1;
				pslverr_o <= ~hit_d;
				prdata_o <= pwrite_i ? 32'h0000_0000 : rd_d;
			end
			else
			begin
				pready_o <= 1'b0;
				pslverr_o <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// configuration writes
	// ****************************************************************
	always @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			ctrl_q <= 2'h0;
			irq_en_q <= 16'h0000;
			lmode_q <= 4'h0;
			for (j = 0; j < 16; j = j + 1)
			begin
				trigger_select_q[j] <= 9'h000;
				op_thr_q[j] <= 32'h0000_0000;
				rel_thr_q[j] <= 32'h0000_0000;
				op_dly_q[j] <= 14'h0001;
				rel_dly_q[j] <= 14'h0001;
				act_q[j] <= 6'h00;
			end
		end
		else if (clk_en_i && wr)
		begin
			// array writes may land mid scan; a setpoint sees them
			// either in this scan or the next, never half applied
			if (in_cfg)
			begin
				case (cfld)
					`F_TRIGGER_SELECT: trigger_select_q[csp] <= pwdata_i[8:0];
					`F_OP_THR: op_thr_q[csp] <= pwdata_i;
					`F_REL_THR: rel_thr_q[csp] <= pwdata_i;
					`F_OP_DLY: op_dly_q[csp] <= pwdata_i[13:0];
					`F_REL_DLY: rel_dly_q[csp] <= pwdata_i[13:0];
					default: act_q[csp] <= pwdata_i[5:0];
				endcase
			end
			else if (paddr_i == `A_CTRL)
				ctrl_q <= pwdata_i[1:0];
			else if (paddr_i == `A_IRQ_EN)
				irq_en_q <= pwdata_i[15:0];
			else if (paddr_i == `A_RLY_LMODE)
				lmode_q <= pwdata_i[3:0];
		end
	end

	// ****************************************************************
	// scan engine: one setpoint per clock after each line cycle tick
	// ****************************************************************
	always @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			busy_q <= 1'b0;
			idx_q <= 4'h0;
			stat_q <= 16'h0000;
			latch_q <= 16'h0000;
			irq_stat_q <= 16'h0000;
			rel_pend_q <= 4'h0;
			rly_acc_q <= 4'h0;
			relay_o <= 4'h0;
			irq_o <= 1'b0;
			for (i = 0; i < 16; i = i + 1)
				tmr_q[i] <= 24'h00_0000;
			for (i = 0; i < 4; i = i + 1)
			begin
				cnt_q[i] <= 20'h0_0000;
				frac_q[i] <= 22'h00_0000;
			end
		end
		else if (clk_en_i)
		begin
			// hardware set wins over a software clear in one cycle
			latch_q <= (latch_q & ~latch_clr)
				| (rise ? one_hot : 16'h0000);
			irq_stat_q <= (irq_stat_q & ~irq_clr)
				| (flip ? one_hot : 16'h0000);
			irq_o <= |(irq_stat_q & irq_en_q);
			// release command pending until the scan end consumes it
			rel_pend_q <= (last ? 4'h0 : rel_pend_q) | rel_cmd;
			// software preset of a counter; a same-cycle hardware
			// step on that counter below takes precedence
			if (wr && in_cnt)
				cnt_q[paddr_i[3:2]] <= pwdata_i[19:0];
			// a tick during a scan is dropped; scans are far shorter
			// than any line cycle
			if (!busy_q)
			begin
				if (cycle_tick_i && ctrl_q[`CTRL_EN_BIT])
				begin
					busy_q <= 1'b1;
					idx_q <= 4'h0;
					rly_acc_q <= 4'h0;
				end
			end
			else
			begin
				// timer runs only while the condition holds
				if (qual && !flip)
					tmr_q[idx_q] <= t_next;
				else
					tmr_q[idx_q] <= 24'h00_0000;
				if (flip)
					stat_q <= stat_q ^ one_hot;
				// action on entry to operated only
				if (rise && act[1:0] == `ACT_COUNT)
					cnt_q[tgt] <= cnt_inc(cnt_q[tgt]);
				// operated time, one count per tenth of an hour
				if (st && act[1:0] == `ACT_TIME)
				begin
					if (frac_next >= `TENTH_HOUR)
					begin
						frac_q[tgt] <= frac_next - `TENTH_HOUR;
						cnt_q[tgt] <= cnt_inc(cnt_q[tgt]);
					end
					else
						frac_q[tgt] <= frac_next;
				end
				rly_acc_q <= rly_acc_q | rly_now;
				idx_q <= idx_q + 4'h1;
				if (last)
				begin
					busy_q <= 1'b0;
					// OR of all linked setpoints; latched relays hold
					// until a release command arrives
					relay_o <= rly_acc_q | rly_now
						| (lmode_q & relay_o & ~rel_pend_q);
				end
			end
		end
	end

endmodule // setpoint_alarm_controller

// ### hdl/setpoint_defines.vh
/*
 * register map, field layout and timing constants of the setpoint
 * controller; assumes a 32-bit apb bus with 12 address bits.
 */
`ifndef SETPOINT_DEFINES_VH
`define SETPOINT_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define A_CTRL 12'h000
`define A_STATUS 12'h004
`define A_LATCH 12'h008
`define A_LATCH_CLR 12'h00C
`define A_RLY_REL 12'h010
`define A_RLY_LMODE 12'h014
`define A_RLY_STATE 12'h018
`define A_IRQ_STAT 12'h01C
`define A_IRQ_CLR 12'h020
`define A_IRQ_EN 12'h024
`define A_CNT_BASE 12'h040
`define A_CFG_BASE 12'h100
`define A_CFG_END 12'h300

// ****************************************************************
// config window fields (word index within a 32-byte slot)
// ****************************************************************
`define F_TRIGGER_SELECT 3'h0
`define F_OP_THR 3'h1
`define F_REL_THR 3'h2
`define F_OP_DLY 3'h3
`define F_REL_DLY 3'h4
`define F_ACT 3'h5
`define TRIGGER_SELECT_BIN_BIT 8
`define CTRL_EN_BIT 0
`define CTRL_60HZ_BIT 1

// ****************************************************************
// action codes
// ****************************************************************
`define ACT_NONE 2'h0
`define ACT_RELAY 2'h1
`define ACT_COUNT 2'h2
`define ACT_TIME 2'h3

// ****************************************************************
// timing, in units of 0.1 ms, and the counter limit
// ****************************************************************
`define PER_60HZ 10'h0A6
`define PER_50HZ 10'h0C8
`define DLY_SCALE 24'h00_03E8
`define TENTH_HOUR 22'h36_EE80
`define CNT_MAX 20'hF_423F

`endif
